// >>> aie_pkg.sv
/*
 * Shared constants for the audio serial input encoder: framing limits,
 * bit-clock timing of the source end and its Wishbone register map.
 * Assumes both ends run on one 10 MHz system clock that also serves
 * as the pixel clock of the encoding end.
 */
package aie_pkg;
    // Clock and bit-clock timing
    localparam int unsigned CLK_PERIOD_NS = 100;        // System / pixel clock period
    localparam int unsigned SCK_PERIOD_NS = 800;        // Bit clock made by the source
    localparam int unsigned SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [2:0]  SCK_HALF_LAST = 3'(SCK_HALF_CYC - 1);

    // Framing limits, in bit-clock periods
    localparam logic [8:0]  FRAME_MIN     = 9'h008;     // Shortest word-select period
    localparam logic [8:0]  FRAME_MAX     = 9'h100;     // Longest word-select period
    localparam logic [8:0]  LOW_MIN       = 9'h001;     // Shortest low phase
    localparam logic [8:0]  LOW_MAX       = 9'h0ff;     // Longest low phase
    localparam logic [8:0]  COUNT_SAT     = 9'h1ff;     // Counter saturation value

    // Source register map (byte addresses)
    localparam logic [3:0]  REG_CTRL      = 4'h0;       // Enable, frame length, low length
    localparam logic [3:0]  REG_PATTERN   = 4'h4;       // Data word sent in every slot
    localparam logic [3:0]  REG_STATUS    = 4'h8;       // Frames sent
    localparam int unsigned CTRL_EN_BIT   = 0;          // Source enable
    localparam int unsigned CTRL_LEN_LSB  = 8;          // Frame length minus one
    localparam int unsigned CTRL_LOW_LSB  = 16;         // Low phase length minus one
    localparam logic [31:0] CTRL_RESET    = 32'h001f_3f00; // 64-bit frame, 32 low
    localparam logic [31:0] PATTERN_RESET = 32'ha5c3_0f96;
endpackage

// >>> aie_link_if.sv
/*
 * Audio link between a source of I2S/TDM frames and the encoding end.
 * Assumes the source drives all three wires and the encoder only reads.
 */
interface aie_link_if;
    logic sck;      // Bit clock, made by the source
    logic ws;       // Word select, frame starts at falling edge
    logic sd;       // Serial data, one bit per bit-clock period

    modport source (output sck, output ws, output sd);
    modport encoder (input sck, input ws, input sd);
endinterface

// >>> aie_encoder.sv
/*
 * Encoding end: samples the audio link with the pixel clock, finds
 * frames and emits captured bits as a stream in the pixel clock domain.
 * Assumes clk_i is the pixel clock and the link wires are asynchronous.
 */
// Operation
// - Carry frame rates 8 to 192 kHz
// - Accept 8-32 bit words, 8-256 bit frames
// - Bit clock unrelated to pixel clock
// - Pack audio into one pixel-clocked stream
// - Audio path enabled straight out of reset
// - Disabled path forwards data as auxiliary signal
// - Frame rate bounded by pixel clock capacity
// - High data rate doubles usable capacity
// - Exceed 192 kHz when capacity allows
// - Spread spectrum leaves audio rates unchanged
// - Accept TDM, I2S and non-standard layouts
// - Word-select period 8 to 256 bits
// - Frame starts at falling WS, low 1-255
// - Data captured on selected bit-clock edge
// - Bits carried transparently, meaning ignored
// - Separate WS and SCK polarity settings
// - Data-rate select one picks low range
module aie_encoder
(
    input  wire logic          clk_i,              // Pixel clock
    input  wire logic          rst_i,              // Synchronous reset, high
    aie_link_if.encoder        link,               // Audio link from source
    input  wire logic          audio_disable_i,    // High turns the audio path off
    input  wire logic          ws_invert_i,        // Word select polarity
    input  wire logic          sck_invert_i,       // Capture on falling edge
    input  wire logic          data_rate_select_i, // One selects low data rate
    input  wire logic          flags_clear_i,      // Clears sticky error flags
    output logic               ser_bit_o,          // Stream bit
    output logic               ser_valid_o,        // Stream bit valid pulse
    output logic               ser_first_o,        // Bit opens a frame
    output logic               aux_o,              // Auxiliary level when disabled
    output logic               overrun_o,          // Sticky: rate above capacity
    output logic               frame_err_o,        // Sticky: framing out of limits
    output logic [8:0]         frame_len_o         // Bits in last full frame
);
    // Three-stage synchronisers, index 0 sck, 1 ws, 2 sd
    logic [2:0] sync1_q;           // First stage, read only by second
    logic [2:0] sync2_q;           // Second stage
    logic [2:0] sync3_q;           // Third stage
    logic [2:0] lvl_q;             // Accepted levels
    logic [2:0] lvl_d;             // Next accepted levels
    wire  [2:0] raw_w = {link.sd, link.ws, link.sck};

    // Frame tracking
    logic       ws_prev_q;         // Word select at previous capture
    logic       seen_q;            // A frame start has been seen
    logic [8:0] bit_cnt_q;         // Bits since frame start
    logic [8:0] low_cnt_q;         // Low word-select bits since start

    // One-bit hand-off to the stream slot
    logic       pend_q;            // Bit waiting for a slot
    logic       pend_bit_q;        // The waiting bit
    logic       pend_first_q;      // The waiting bit opens a frame
    logic       slot_q;            // Slot phase for low data rate

    // Synchroniser chain, all three wires see equal latency
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            // Level accepted once second and third stages agree
            assign lvl_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : lvl_q[g];

            // Stages and accepted level
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    sync3_q[g] <= 1'b0;
                    lvl_q[g]   <= 1'b0;
                end
                else
                begin
                    sync1_q[g] <= raw_w[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                    lvl_q[g]   <= lvl_d[g];
                end
            end
        end
    endgenerate

    // Framing limits at counter width
    localparam logic [8:0] FRAME_MIN_W = aie_pkg::FRAME_MIN;
    localparam logic [8:0] FRAME_MAX_W = aie_pkg::FRAME_MAX;
    localparam logic [8:0] LOW_MIN_W   = aie_pkg::LOW_MIN;
    localparam logic [8:0] LOW_MAX_W   = aie_pkg::LOW_MAX;
    localparam logic [8:0] SAT_W       = aie_pkg::COUNT_SAT;

    // Active bit-clock edge, polarity selectable
    wire cap_w   = (lvl_d[0] != lvl_q[0]) && (lvl_d[0] ^ sck_invert_i);
    // Word select after polarity, sampled at the capture edge
    wire ws_w    = lvl_q[1] ^ ws_invert_i;
    wire sd_w    = lvl_q[2];
    wire start_w = cap_w && ws_prev_q && !ws_w;
    wire en_w    = !audio_disable_i;
    // Any frame shape inside the limits is taken; no layout is assumed
    wire len_bad_w = (bit_cnt_q < FRAME_MIN_W) || (bit_cnt_q > FRAME_MAX_W);
    wire low_bad_w = (low_cnt_q < LOW_MIN_W) || (low_cnt_q > LOW_MAX_W);
    wire bad_w     = start_w && seen_q && (len_bad_w || low_bad_w);

    // Slot is every pixel clock at high rate, every second at low rate.
    // Spread spectrum is not an input here, so the slot cadence and
    // thus the audio bit rate cannot move with it.
    wire slot_w  = !data_rate_select_i || slot_q;
    wire send_w  = pend_q && slot_w;
    // A new bit while the old one still waits means the rate is too high
    wire lost_w  = cap_w && en_w && pend_q && !slot_w;

    // Frame counters, saturating so long frames stay flagged
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ws_prev_q   <= 1'b0;
            seen_q      <= 1'b0;
            bit_cnt_q   <= 9'h000;
            low_cnt_q   <= 9'h000;
            frame_len_o <= 9'h000;
        end
        else if (cap_w)
        begin
            ws_prev_q <= ws_w;
            if (start_w)
            begin
                // Start bit itself is the first low bit
                seen_q      <= 1'b1;
                bit_cnt_q   <= 9'h001;
                low_cnt_q   <= 9'h001;
                frame_len_o <= seen_q ? bit_cnt_q : frame_len_o;
            end
            else
            begin
                bit_cnt_q <= (bit_cnt_q == SAT_W) ? bit_cnt_q : bit_cnt_q + 9'h001;
                // Low phase counted only while word select stays low
                if (!ws_w && !ws_prev_q && low_cnt_q != SAT_W)
                begin
                    low_cnt_q <= low_cnt_q + 9'h001;
                end
            end
        end
    end

    // Pending bit: taken at capture, released at the next slot.
    // No deeper buffer; a rate within limits never needs one.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_q       <= 1'b0;
            pend_bit_q   <= 1'b0;
            pend_first_q <= 1'b0;
            slot_q       <= 1'b0;
        end
        else
        begin
            slot_q <= !slot_q;
            if (cap_w && en_w)
            begin
                // Bit kept as seen, no reordering or interpretation
                pend_q       <= 1'b1;
                pend_bit_q   <= sd_w;
                pend_first_q <= start_w;
            end
            else if (send_w)
            begin
                pend_q <= 1'b0;
            end
        end
    end

    // Stream outputs, all registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ser_valid_o <= 1'b0;
            ser_bit_o   <= 1'b0;
            ser_first_o <= 1'b0;
            aux_o       <= 1'b0;
        end
        else
        begin
            ser_valid_o <= send_w && en_w;
            ser_bit_o   <= send_w ? pend_bit_q : ser_bit_o;
            ser_first_o <= send_w && pend_first_q;
            // Disabled path passes the data level straight on
            aux_o       <= en_w ? 1'b0 : sd_w;
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            overrun_o   <= 1'b0;
            frame_err_o <= 1'b0;
        end
        else
        begin
            overrun_o   <= lost_w || (overrun_o && !flags_clear_i);
            frame_err_o <= bad_w || (frame_err_o && !flags_clear_i);
        end
    end
endmodule

// >>> aie_source.sv
/*
 * Source end: makes the bit clock by dividing its own clock and sends
 * frames of a programmable shape. Software drives it over classic
 * Wishbone. Assumes the encoder captures on the rising bit-clock edge.
 */
module aie_source
(
    input  wire logic          clk_i,      // System clock
    input  wire logic          rst_i,      // Synchronous reset, high
    aie_link_if.source         link,       // Audio link to encoder
    input  wire logic          cyc_i,      // Wishbone cycle
    input  wire logic          stb_i,      // Wishbone strobe
    input  wire logic          we_i,       // Wishbone write
    input  wire logic [3:0]    adr_i,      // Byte address
    input  wire logic [3:0]    sel_i,      // Byte enables
    input  wire logic [31:0]   dat_i,      // Write data
    output logic [31:0]        dat_o,      // Read data
    output logic               ack_o       // Acknowledge
);
    logic [31:0] ctrl_q;       // Control register
    logic [31:0] pat_q;        // Data pattern
    logic [31:0] frames_q;     // Frames sent
    logic [2:0]  div_q;        // Half-period divider
    logic        sck_q;        // Bit clock
    logic        ws_q;         // Word select
    logic        sd_q;         // Serial data
    logic [7:0]  bit_q;        // Bit index in frame

    // Byte-enable merge, used for both writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                merge[8*i +: 8] = nw[8*i +: 8];
            end
        end
    endfunction

    wire        req_w   = cyc_i && stb_i && !ack_o;
    wire        wr_w    = req_w && we_i;
    wire        en_w    = ctrl_q[aie_pkg::CTRL_EN_BIT];
    wire [7:0]  last_w  = ctrl_q[aie_pkg::CTRL_LEN_LSB +: 8];
    wire [7:0]  lowl_w  = ctrl_q[aie_pkg::CTRL_LOW_LSB +: 8];
    wire        fall_w  = en_w && (div_q == aie_pkg::SCK_HALF_LAST) && sck_q;
    wire [7:0]  nbit_w  = (bit_q == last_w) ? 8'h00 : bit_q + 8'h01;
    wire [31:0] rd_w    = (adr_i == aie_pkg::REG_CTRL)    ? ctrl_q :
                          (adr_i == aie_pkg::REG_PATTERN) ? pat_q :
                          (adr_i == aie_pkg::REG_STATUS)  ? frames_q : 32'h0000_0000;

    // Bus slave: one wait state, ack drops the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o  <= 1'b0;
            dat_o  <= 32'h0000_0000;
            ctrl_q <= aie_pkg::CTRL_RESET;
            pat_q  <= aie_pkg::PATTERN_RESET;
        end
        else
        begin
            ack_o <= req_w;
            dat_o <= req_w ? rd_w : dat_o;
            if (wr_w && adr_i == aie_pkg::REG_CTRL)
            begin
                ctrl_q <= merge(ctrl_q, dat_i, sel_i);
            end
            if (wr_w && adr_i == aie_pkg::REG_PATTERN)
            begin
                pat_q <= merge(pat_q, dat_i, sel_i);
            end
        end
    end

    // Bit clock divider; the clock stops low while disabled
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_w)
        begin
            div_q <= 3'h0;
            sck_q <= 1'b0;
        end
        else
        begin
            div_q <= (div_q == aie_pkg::SCK_HALF_LAST) ? 3'h0 : div_q + 3'h1;
            sck_q <= (div_q == aie_pkg::SCK_HALF_LAST) ? !sck_q : sck_q;
        end
    end

    // Data and word select change on the falling edge, so the encoder
    // sees them stable a half period around its rising capture edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bit_q    <= 8'h00;
            ws_q     <= 1'b1;
            sd_q     <= 1'b0;
            frames_q <= 32'h0000_0000;
        end
        else if (fall_w)
        begin
            bit_q    <= nbit_w;
            ws_q     <= (nbit_w > lowl_w);
            sd_q     <= pat_q[5'h1f - nbit_w[4:0]];
            frames_q <= (nbit_w == 8'h00) ? frames_q + 32'h0000_0001 : frames_q;
        end
    end

    assign link.sck = sck_q;
    assign link.ws  = ws_q;
    assign link.sd  = sd_q;
endmodule

// >>> aie_props.sv
/*
 * Checker beside the audio link: bus answer, stream pacing and flags.
 * Assumes one clock for both ends; signals arrive as plain inputs.
 */
module aie_props
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic sck_i,
    input  wire logic ws_i,
    input  wire logic cyc_i,
    input  wire logic stb_i,
    input  wire logic ack_o,
    input  wire logic audio_disable_i,
    input  wire logic ws_invert_i,
    input  wire logic sck_invert_i,
    input  wire logic flags_clear_i,
    input  wire logic ser_valid_o,
    input  wire logic ser_first_o,
    input  wire logic aux_o,
    input  wire logic overrun_o,
    input  wire logic frame_err_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Bus request while no answer is pending
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    // Audio path held on for three cycles
    sequence on_s;
        !audio_disable_i [*3];
    endsequence
    // Rising bit clock, capture polarity steady for a while
    sequence sck_rise_s;
        $rose(sck_i) && !sck_invert_i && !$past(sck_invert_i, 8);
    endsequence
    // Falling word select, polarity steady for a while
    sequence ws_fall_s;
        $fell(ws_i) && !ws_invert_i && !$past(ws_invert_i, 8);
    endsequence

    ack_answer_a: assert property (req_s |=> ack_o) else $error("no ack");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
        else $error("ack without request");
    first_valid_a: assert property (ser_first_o |-> ser_valid_o)
        else $error("first without valid");
    valid_gap_a: assert property (ser_valid_o |=> !ser_valid_o [*3])
        else $error("bit duplicated");
    quiet_off_a: assert property (audio_disable_i [*3] |-> !ser_valid_o)
        else $error("stream while disabled");
    aux_low_a: assert property (on_s |-> !aux_o)
        else $error("aux while enabled");
    err_sticky_a: assert property (frame_err_o && !flags_clear_i |=> frame_err_o)
        else $error("frame error lost");
    ovr_sticky_a: assert property (overrun_o && !flags_clear_i |=> overrun_o)
        else $error("overrun lost");
    // Slack covers the synchroniser and the slow slot phase
    bit_carry_a: assert property (sck_rise_s ##1 on_s |-> ##[1:5] ser_valid_o)
        else $error("bit not carried");
    frame_start_a: assert property (ws_fall_s ##1 on_s |-> ##[1:12] ser_first_o)
        else $error("frame start missed");
endmodule

// >>> tb.sv
/*
 * Testbench: source and encoder joined by the link interface.
 * Assumes a 10 MHz clock shared by both ends and a Wishbone-driven source.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, cyc, stb, we, dis, wsi, scki, data_rate_select, fclr;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat, r;
    logic        ack, sbit, svld, sfirst, aux, ovr, ferr, chk_bits, exp_bit;
    logic [8:0]  flen;
    int          error_cnt = 0, samples_checked = 0, frames_seen = 0, valid_cnt = 0;
    int          bits_cnt = 0, last_bits = 0, len, low, vc;
    logic [31:0] rv [4] = '{aie_pkg::CTRL_RESET, aie_pkg::PATTERN_RESET, 32'h0, 32'h0};

    aie_link_if link_if();
    aie_source aie_source_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_if.source),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack));
    aie_encoder aie_encoder_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_if.encoder),
        .audio_disable_i(dis), .ws_invert_i(wsi), .sck_invert_i(scki),
        .data_rate_select_i(data_rate_select), .flags_clear_i(fclr), .ser_bit_o(sbit),
        .ser_valid_o(svld), .ser_first_o(sfirst), .aux_o(aux), .overrun_o(ovr),
        .frame_err_o(ferr), .frame_len_o(flen));
    aie_props aie_props_inst (.clk_i(clk_i), .rst_i(rst_i), .sck_i(link_if.sck),
        .ws_i(link_if.ws), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .audio_disable_i(dis),
        .ws_invert_i(wsi), .sck_invert_i(scki), .flags_clear_i(fclr),
        .ser_valid_o(svld), .ser_first_o(sfirst), .aux_o(aux), .overrun_o(ovr),
        .frame_err_o(ferr));

    // Verdict and end of run
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Frame shape outside the framing limits, from the package constants
    function automatic logic frame_bad(input int fl, input int lo);
        frame_bad = (fl < int'(aie_pkg::FRAME_MIN)) || (fl > int'(aie_pkg::FRAME_MAX)) ||
                    (lo < int'(aie_pkg::LOW_MIN)) || (lo > int'(aie_pkg::LOW_MAX));
    endfunction

    // One classic Wishbone cycle; read data lands in r
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            error_cnt++;
            test_done();
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Bounded wait for n frame starts; longest frame is 2048 clocks
    task automatic wait_frames(input int n);
        int t0, k;
        t0 = frames_seen;
        k = 0;
        while (frames_seen < t0 + n && k < 3000 * n)
        begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 3000 * n)
        begin
            error_cnt++;
            test_done();
        end
    endtask

    // Program a frame shape, clear flags once settled, then check counts
    task automatic shape(input int fl, input int lo);
        wb(1'b1, aie_pkg::REG_CTRL, {8'h00, 8'(lo - 1), 8'(fl - 1), 8'h01});
        // A shape or polarity change can leave a spurious start and one odd frame
        wait_frames(2);
        fclr <= 1'b1;
        @(posedge clk_i);
        fclr <= 1'b0;
        wait_frames(2);
        check(32'(flen), fl);
        check(last_bits, fl);
        check(32'(ferr), 32'(frame_bad(fl, lo)));
        check(32'(ovr), 32'h0);
    endtask

    // Stream monitor: bits per frame and the expected data level
    always @(posedge clk_i)
    begin
        if (svld === 1'b1)
        begin
            valid_cnt++;
            if (chk_bits)
                check(32'(sbit), 32'(exp_bit));
            if (sfirst === 1'b1)
            begin
                frames_seen++;
                last_bits = bits_cnt;
                bits_cnt = 1;
            end
            else
                bits_cnt++;
        end
    end

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial
    begin
        {rst_i, cyc, stb, we, dis, wsi, scki, data_rate_select, fclr, chk_bits, exp_bit} = 11'h400;
        adr = 4'h0;
        wdat = 32'h0;
        void'($urandom(55));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, then read-only and unmapped places
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b0, 4'(i * 4), 32'h0);
            check(r, rv[i]);
        end
        for (int i = 2; i < 4; i++)
        begin
            wb(1'b1, 4'(i * 4), 32'hffff_ffff);
            wb(1'b0, 4'(i * 4), 32'h0);
            check(r, 32'h0);
        end
        check(32'({svld, aux, ovr, ferr, flen}), 32'h0);
        $display("reset test done");
        // Constant patterns must come through untouched
        wb(1'b1, aie_pkg::REG_PATTERN, 32'hffff_ffff);
        shape(64, 32);
        exp_bit = 1'b1;
        chk_bits = 1'b1;
        wait_frames(2);
        chk_bits = 1'b0;
        wb(1'b1, aie_pkg::REG_PATTERN, 32'h0);
        wait_frames(1);
        exp_bit = 1'b0;
        chk_bits = 1'b1;
        wait_frames(2);
        chk_bits = 1'b0;
        wb(1'b0, aie_pkg::REG_STATUS, 32'h0);
        check(32'(|r), 32'h1);
        $display("data test done");
        // Frame shapes: both corners then random ones, rate select toggled
        for (int i = 0; i < 5; i++)
        begin
            len = (i == 0) ? 8 : (i == 1) ? 256 : 8 + $urandom % 249;
            low = (i == 0) ? 1 : (i == 1) ? 255 : 1 + $urandom % (len - 1);
            data_rate_select <= i[0];
            shape(len, low);
        end
        data_rate_select <= 1'b0;
        $display("shape test done");
        // Frames shorter than the minimum are flagged
        shape(4, 1);
        shape(7, 1);
        $display("error test done");
        // Inverted word select and capture edge
        wsi <= 1'b1;
        scki <= 1'b1;
        shape(64, 16);
        wsi <= 1'b0;
        scki <= 1'b0;
        shape(64, 32);
        $display("polarity test done");
        // Disabled path forwards data as a plain level
        wb(1'b1, aie_pkg::REG_PATTERN, 32'hffff_ffff);
        dis <= 1'b1;
        repeat (20) @(posedge clk_i);
        vc = valid_cnt;
        repeat (300) @(posedge clk_i);
        check(valid_cnt - vc, 32'h0);
        check(32'(aux), 32'h1);
        dis <= 1'b0;
        shape(64, 32);
        $display("disable test done");
        test_done();
    end
endmodule
